// file: common/nbi_pkg.sv
// Package of constants and types for the NAND asynchronous bus host controller
package nbi_pkg;
	localparam int CLK_MHZ = 250;
	localparam int READ_CYCLE_TIME_NS = 30;
	localparam int STROBE_LOW_CYC = (READ_CYCLE_TIME_NS * CLK_MHZ / 1000 + 1) / 2;
	localparam int STROBE_HIGH_CYC = STROBE_LOW_CYC;
	localparam int POWER_WAIT_US = 100;
	localparam int POWER_WAIT_CYC = POWER_WAIT_US * CLK_MHZ;
	localparam int WRITE_PROTECT_SETTLE_TIME_NS = 100;
	localparam int WP_SETTLE_CYC = (WRITE_PROTECT_SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_BUSY_US = 1000;
	localparam int RESET_BUSY_CYC = RESET_BUSY_US * CLK_MHZ;
	localparam int TIMER_W = 20;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_STATUS_ENH = 8'h78;
	localparam logic [7:0] CMD_READ_MODE = 8'h00;
	localparam int ADDR_CYCLES = 5;
	localparam int CA12_BIT = 4;
	localparam logic [7:0] ADDR2_MASK = 8'h1F;
	localparam logic [7:0] ADDR5_MASK = 8'h01;
	localparam logic [3:0] CA_HIGH_MASK = 4'hF;
	typedef enum logic [1:0] {NBI_OP_CMD, NBI_OP_ADDR, NBI_OP_WRITE, NBI_OP_READ} nbi_op_t;
	typedef struct packed {
		nbi_op_t op;
		logic [7:0] data;
	} nbi_req_t;
	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic write_strobe_n;
		logic read_strobe_n;
	} nbi_ctl_t;
endpackage : nbi_pkg

// file: core/nbi_strobe.sv
// Strobe timer: counts one low and one high phase of a bus strobe
`timescale 1ns/1ps
`default_nettype none
module nbi_strobe
	import nbi_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic start,
	output logic low_phase,
	output logic sample,
	output logic done
);
	typedef enum logic [1:0] {NBI_S_IDLE, NBI_S_LOW, NBI_S_HIGH} nbi_sph_t;
	nbi_sph_t phase;
	nbi_sph_t next_phase;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	always_comb
	begin
		next_phase = phase;
		next_cnt = cnt;
		case (phase)
			NBI_S_IDLE:
			begin
				if (start)
				begin
					next_phase = NBI_S_LOW;
					next_cnt = 4'(STROBE_LOW_CYC - 1);
				end
			end
			NBI_S_LOW:
			begin
				if (cnt == 4'h0)
				begin
					next_phase = NBI_S_HIGH;
					next_cnt = 4'(STROBE_HIGH_CYC - 1);
				end
				else
					next_cnt = cnt - 4'h1;
			end
			NBI_S_HIGH:
			begin
				if (cnt == 4'h0)
					next_phase = NBI_S_IDLE;
				else
					next_cnt = cnt - 4'h1;
			end
			default:
				next_phase = NBI_S_IDLE;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			phase <= NBI_S_IDLE;
			cnt <= 4'h0;
		end
		else if (clk_en)
		begin
			phase <= next_phase;
			cnt <= next_cnt;
		end
	end
	assign low_phase = (phase == NBI_S_LOW);
	// Last low cycle: the 32ns cycle (4 low, 4 high) lets data be taken at the rising edge
	assign sample = (phase == NBI_S_LOW) && (cnt == 4'h0);
	assign done = (phase == NBI_S_HIGH) && (cnt == 4'h0);
endmodule : nbi_strobe
`default_nettype wire

// file: core/nbi_host.sv
// Host controller for the NAND asynchronous multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module nbi_host
	import nbi_pkg::*;
#(
	parameter int POWER_WAIT = POWER_WAIT_CYC,
	parameter int RESET_TIMEOUT = RESET_BUSY_CYC
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic req_valid,
	output logic req_ready,
	input wire nbi_req_t req,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	input wire logic write_protect_req,
	output logic init_done,
	output nbi_ctl_t bus_ctl,
	output logic write_protect_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic ready_busy_n
);
	////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {NBI_PWR, NBI_RST_CMD, NBI_RST_WAIT, NBI_IDLE,
		NBI_XFER, NBI_WP_SETTLE} nbi_st_t;
	nbi_st_t st;
	nbi_st_t next_st;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	nbi_req_t cur;
	nbi_req_t next_cur;
	logic [2:0] addr_idx;
	logic [2:0] next_addr_idx;
	logic ca12;
	logic next_ca12;
	logic wp;
	logic next_wp;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic rvalid;
	logic next_rvalid;
	logic strobe_start;
	logic low_phase;
	logic sample;
	logic done;
	nbi_strobe u_strobe (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.start(strobe_start),
		.low_phase(low_phase),
		.sample(sample),
		.done(done)
	);
	// Zero bits outside the address space for the current cycle
	function automatic logic [7:0] addr_clean(input logic [2:0] idx, input logic c12,
		input logic [7:0] b);
		logic [7:0] v;
		v = b;
		if (idx == 3'd1)
		begin
			v = b & ADDR2_MASK;
			if (v[CA12_BIT])
				v[3:0] = v[3:0] & ~CA_HIGH_MASK;
		end
		else if (idx >= 3'(ADDR_CYCLES - 1))
			v = b & ADDR5_MASK;
		return v;
	endfunction : addr_clean
	////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_st = st;
		next_timer = timer;
		next_cur = cur;
		next_addr_idx = addr_idx;
		next_ca12 = ca12;
		next_wp = wp;
		next_rdata = rdata;
		next_rvalid = 1'b0;
		strobe_start = 1'b0;
		case (st)
			NBI_PWR:
			begin
				// Both waits are needed; ready/busy is only checked after the timer expires
				if (timer != '0)
					next_timer = timer - 1'b1;
				else if (ready_busy_n)
				begin
					next_st = NBI_RST_CMD;
					next_cur.op = NBI_OP_CMD;
					next_cur.data = CMD_RESET;
					strobe_start = 1'b1;
				end
			end
			NBI_RST_CMD:
			begin
				if (done)
				begin
					next_st = NBI_RST_WAIT;
					next_timer = TIMER_W'(RESET_TIMEOUT);
				end
			end
			NBI_RST_WAIT:
			begin
				// Busy for up to 1ms after reset; ready/busy ends it early
				if (timer != '0)
					next_timer = timer - 1'b1;
				if (timer == '0 || (timer < TIMER_W'(RESET_TIMEOUT - 4) && ready_busy_n))
					next_st = NBI_IDLE;
			end
			NBI_IDLE:
			begin
				if (write_protect_req != wp && ready_busy_n)
				begin
					next_wp = write_protect_req;
					next_st = NBI_WP_SETTLE;
					next_timer = TIMER_W'(WP_SETTLE_CYC);
				end
				else if (req_valid)
				begin
					next_cur = req;
					if (req.op == NBI_OP_CMD)
					begin
						next_addr_idx = 3'd0;
						next_ca12 = 1'b0;
					end
					if (req.op == NBI_OP_ADDR)
					begin
						next_cur.data = addr_clean(addr_idx, ca12, req.data);
						if (addr_idx == 3'd1)
							next_ca12 = req.data[CA12_BIT];
						// Count one past the last cycle so the fifth transfer stays recognisable
						if (addr_idx != 3'(ADDR_CYCLES))
							next_addr_idx = addr_idx + 3'd1;
					end
					next_st = NBI_XFER;
					strobe_start = 1'b1;
				end
			end
			NBI_XFER:
			begin
				if (sample && cur.op == NBI_OP_READ)
				begin
					next_rdata = io_in;
					next_rvalid = 1'b1;
				end
				if (done)
					next_st = NBI_IDLE;
			end
			NBI_WP_SETTLE:
			begin
				if (timer != '0)
					next_timer = timer - 1'b1;
				else
					next_st = NBI_IDLE;
			end
			default:
				next_st = NBI_PWR;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			st <= NBI_PWR;
			timer <= TIMER_W'(POWER_WAIT);
			cur <= '0;
			addr_idx <= 3'd0;
			ca12 <= 1'b0;
			wp <= 1'b0;
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end
		else if (clk_en)
		begin
			st <= next_st;
			timer <= next_timer;
			cur <= next_cur;
			addr_idx <= next_addr_idx;
			ca12 <= next_ca12;
			wp <= next_wp;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end
	////////////////////////////////////////////////////////////////
	logic active;
	assign active = (st == NBI_XFER) || (st == NBI_RST_CMD);
	assign req_ready = (st == NBI_IDLE) && (write_protect_req == wp || !ready_busy_n);
	assign rsp_valid = rvalid;
	assign rsp_data = rdata;
	assign init_done = (st == NBI_IDLE) || (st == NBI_XFER) || (st == NBI_WP_SETTLE);
	// Write protect line is driven in every state, selected or not
	assign write_protect_n = wp;
	// Deselect between transfers lets the target fall to standby
	assign bus_ctl.ce_n = !active;
	assign bus_ctl.cle = active && cur.op == NBI_OP_CMD;
	assign bus_ctl.ale = active && cur.op == NBI_OP_ADDR;
	assign bus_ctl.write_strobe_n = !(active && low_phase && cur.op != NBI_OP_READ);
	assign bus_ctl.read_strobe_n = !(active && low_phase && cur.op == NBI_OP_READ);
	// Drive the bus only for host writes; the device drives during reads
	assign io_oe = active && cur.op != NBI_OP_READ;
	assign io_out = cur.data;
	////////////////////////////////////////////////////////////////
	sequence s_cmd_low;
		!bus_ctl.write_strobe_n && bus_ctl.cle && !bus_ctl.ale;
	endsequence
	a_cmd_latch: assert property (@(posedge clk) disable iff (!reset_n)
		s_cmd_low ##1 bus_ctl.write_strobe_n |-> bus_ctl.read_strobe_n && !bus_ctl.ce_n)
		else $error("command strobe without proper enables");
	a_addr_latch: assert property (@(posedge clk) disable iff (!reset_n)
		!bus_ctl.write_strobe_n && bus_ctl.ale |-> !bus_ctl.cle && bus_ctl.read_strobe_n)
		else $error("address cycle with bad latch enables");
	a_addr_mask: assert property (@(posedge clk) disable iff (!reset_n)
		bus_ctl.ale && io_oe && addr_idx == 3'(ADDR_CYCLES) |-> io_out[7:1] == 7'h00)
		else $error("fifth address cycle has high unused bits");
	a_col_high: assert property (@(posedge clk) disable iff (!reset_n)
		bus_ctl.ale && io_oe && addr_idx == 3'd2 && io_out[CA12_BIT]
		|-> io_out[3:0] == 4'h0 && io_out[7:5] == 3'h0)
		else $error("second column cycle keeps high column bits");
	a_read_nodrive: assert property (@(posedge clk) disable iff (!reset_n)
		!bus_ctl.read_strobe_n |-> !io_oe && bus_ctl.write_strobe_n)
		else $error("host drives bus during read");
	a_first_reset: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(bus_ctl.cle) && $past(st) == NBI_PWR |-> io_out == CMD_RESET)
		else $error("first command is not reset");
	a_wp_power: assert property (@(posedge clk) disable iff (!reset_n)
		st == NBI_PWR |-> !write_protect_n)
		else $error("write protect high during power-on");
	a_wp_idle: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(write_protect_n) |-> $past(ready_busy_n) && $past(st) == NBI_IDLE)
		else $error("write protect changed while busy");
	a_standby: assert property (@(posedge clk) disable iff (!reset_n)
		st == NBI_IDLE |-> bus_ctl.ce_n && bus_ctl.write_strobe_n && bus_ctl.read_strobe_n)
		else $error("target selected while idle");
endmodule : nbi_host
`default_nettype wire

// file: bench/nbi_flash_model.sv
// Behavioural NAND target answering the host controller
`timescale 1ns/1ps
`default_nettype none
module nbi_flash_model
	import nbi_pkg::*;
#(
	parameter int RESET_BUSY = 30,
	parameter int PROG_BUSY = 200
)
(
	input wire logic clk,
	input wire nbi_ctl_t bus_ctl,
	input wire logic write_protect_n,
	input wire logic [7:0] io_in,
	output logic [7:0] dev_data,
	output logic dev_oe,
	output logic busy_low
);
	logic [7:0] cache [16];
	logic [7:0] addr [5];
	logic [7:0] last_cmd;
	logic status_mode;
	logic first_ok;
	logic busy;
	int ptr;
	int n_addr;
	int n_cmd;
	int cyc;
	int busy_until;
	int reset_cyc;
	// Asynchronous interface from power-on, no set-up step
	initial
	begin
		{status_mode, first_ok, dev_oe, last_cmd} = '0;
	end
	always @(posedge clk)
		cyc++;
	assign busy = cyc < busy_until;
	assign busy_low = busy;
	//////////////////////////////////////////////////////////////////////////////
	always @(posedge bus_ctl.write_strobe_n)
		if (!bus_ctl.ce_n && bus_ctl.read_strobe_n)
			if (bus_ctl.cle && !bus_ctl.ale)
			begin
				if (!busy || io_in inside {CMD_READ_STATUS, CMD_READ_STATUS_ENH, CMD_RESET})
				begin
					if (n_cmd == 0)
						first_ok = io_in == CMD_RESET;
					n_cmd++;
					last_cmd = io_in;
					ptr = 0;
					n_addr = 0;
					status_mode = io_in inside {CMD_READ_STATUS, CMD_READ_STATUS_ENH};
					if (io_in == CMD_RESET)
					begin
						busy_until = cyc + RESET_BUSY;
						reset_cyc = cyc;
					end
					// Program confirm starts nothing while protected
					if (io_in == 8'h10 && write_protect_n)
						busy_until = cyc + PROG_BUSY;
				end
			end
			else if (bus_ctl.ale && !bus_ctl.cle)
			begin
				if ((!busy || last_cmd == CMD_READ_STATUS_ENH) && n_addr < 5)
				begin
					addr[n_addr] = io_in;
					n_addr++;
				end
			end
			else if (!bus_ctl.ale && !bus_ctl.cle && !busy)
			begin
				cache[ptr] = io_in;
				ptr++;
			end
	always @(negedge bus_ctl.read_strobe_n)
		if (!bus_ctl.ce_n && !bus_ctl.cle && !bus_ctl.ale && bus_ctl.write_strobe_n)
			if (status_mode)
			begin
				dev_data = {write_protect_n, !busy, 6'h00};
				dev_oe = 1'b1;
			end
			else if (!busy)
			begin
				dev_data = cache[ptr];
				ptr++;
				dev_oe = 1'b1;
			end
	// Drivers off at once so the shared bus is free for others
	always @(posedge bus_ctl.read_strobe_n or posedge bus_ctl.ce_n)
		dev_oe = 1'b0;
endmodule : nbi_flash_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import nbi_pkg::*;
	logic clk, reset_n, req_valid, req_ready, rsp_valid, write_protect_req, init_done;
	logic write_protect_n, io_oe, dev_oe, busy_low, clk_en;
	logic [7:0] rsp_data, io_out, dev_data, io_bus, last_bus;
	logic [7:0] wd [4];
	logic [7:0] ad [5];
	logic [7:0] expq [$];
	logic [31:0] rng;
	nbi_req_t req;
	nbi_ctl_t bus_ctl;
	int n_fail, n_checks, k;
	// Released bus shows the inverse of its last level, never a held value
	assign io_bus = io_oe ? io_out : (dev_oe ? dev_data : ~last_bus);
	always @(posedge clk)
		if (io_oe || dev_oe)
			last_bus <= io_bus;
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	nbi_host #(.POWER_WAIT(20), .RESET_TIMEOUT(50)) u_nbi_host (.clk(clk), .reset_n(reset_n),
		.clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .write_protect_req(write_protect_req),
		.init_done(init_done), .bus_ctl(bus_ctl), .write_protect_n(write_protect_n),
		.io_out(io_out), .io_oe(io_oe), .io_in(io_bus), .ready_busy_n(!busy_low));
	nbi_flash_model u_nbi_flash_model (.clk(clk), .bus_ctl(bus_ctl),
		.write_protect_n(write_protect_n), .io_in(io_bus), .dev_data(dev_data),
		.dev_oe(dev_oe), .busy_low(busy_low));
	//////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	task automatic stall(input string what);
		check(what, 8'h00, 8'h01);
		summarize();
	endtask : stall
	task automatic do_req(input nbi_op_t op, input logic [7:0] data);
		int i;
		@(posedge clk);
		#1;
		req = '{op: op, data: data};
		req_valid = 1'b1;
		for (i = 0; i < 400 && req_ready !== 1'b1; i++)
			@(negedge clk);
		if (i == 400)
			stall("request taken");
		@(posedge clk);
		#1;
		req_valid = 1'b0;
	endtask : do_req
	task automatic prog_page(input int n);
		do_req(NBI_OP_CMD, 8'h80);
		for (int i = 0; i < 5; i++)
			do_req(NBI_OP_ADDR, ad[i]);
		for (int i = 0; i < n; i++)
			do_req(NBI_OP_WRITE, wd[i]);
		do_req(NBI_OP_CMD, 8'h10);
		repeat (10) @(posedge clk);
	endtask : prog_page
	//////////////////////////////////////////////////////////////////////////////
	always @(negedge clk)
	begin
		if (rsp_valid === 1'b1 && expq.size() > 0)
			check("read byte", rsp_data, expq.pop_front());
		else if (rsp_valid === 1'b1)
			check("spare read", 8'h01, 8'h00);
		if (dev_oe === 1'b1)
			check("bus contention", 8'(io_oe), 8'h00);
	end
	initial
	begin
		{reset_n, req_valid, write_protect_req, last_bus} = '0;
		clk_en = 1'b1;
		req = '0;
		rng = 32'h5E07;
		repeat (10) @(posedge clk);
		check("chip enable in reset", 8'(bus_ctl.ce_n), 8'h01);
		check("protect in reset", 8'(write_protect_n), 8'h00);
		#1;
		reset_n = 1'b1;
		for (k = 0; k < 400 && init_done !== 1'b1; k++)
			@(negedge clk);
		if (k == 400)
			stall("init done");
		check("first command", 8'(u_nbi_flash_model.first_ok), 8'h01);
		check("reset wait", 8'(u_nbi_flash_model.cyc - u_nbi_flash_model.reset_cyc >= 30), 8'h01);
		// Frozen clock enable: an offered request must not be taken
		@(posedge clk);
		#1;
		clk_en = 1'b0;
		do_req(NBI_OP_READ, 8'h00);
		repeat (4) @(negedge clk);
		check("frozen bus", 8'(bus_ctl.ce_n), 8'h01);
		@(posedge clk);
		#1;
		clk_en = 1'b1;
		do_req(NBI_OP_CMD, CMD_READ_STATUS);
		expq.push_back(8'h40);
		do_req(NBI_OP_READ, 8'h00);
		for (k = 0; k < 4; k++)
		begin
			rng = xs(rng);
			wd[k] = rng[7:0];
		end
		ad = '{rng[15:8], 8'hFF, rng[23:16], rng[31:24], 8'hFF};
		prog_page(4);
		check("busy while protected", 8'(busy_low), 8'h00);
		for (k = 0; k < 5; k++)
			check("address", u_nbi_flash_model.addr[k], k == 1 ? 8'h10 : k == 4 ? 8'h01 : ad[k]);
		do_req(NBI_OP_CMD, CMD_READ_MODE);
		for (k = 0; k < 4; k++)
		begin
			expq.push_back(wd[k]);
			do_req(NBI_OP_READ, 8'h00);
		end
		write_protect_req = 1'b1;
		wd[0] = ~wd[0];
		prog_page(1);
		check("busy after program", 8'(busy_low), 8'h01);
		do_req(NBI_OP_CMD, CMD_READ_STATUS);
		expq.push_back(8'h80);
		do_req(NBI_OP_READ, 8'h00);
		do_req(NBI_OP_CMD, CMD_READ_STATUS_ENH);
		for (k = 0; k < 3; k++)
			do_req(NBI_OP_ADDR, 8'h33);
		repeat (10) @(posedge clk);
		check("addresses while busy", 8'(u_nbi_flash_model.n_addr), 8'h03);
		do_req(NBI_OP_CMD, CMD_READ_MODE);
		expq.push_back(8'h80);
		do_req(NBI_OP_READ, 8'h00);
		for (k = 0; k < 400 && busy_low !== 1'b0; k++)
			@(negedge clk);
		if (k == 400)
			stall("ready again");
		do_req(NBI_OP_CMD, CMD_READ_MODE);
		expq.push_back(wd[0]);
		do_req(NBI_OP_READ, 8'h00);
		repeat (10) @(posedge clk);
		check("reads left", 8'(expq.size()), 8'h00);
		summarize();
	end
endmodule : testbench
`default_nettype wire
